// File: hw/lpd_regs.svh
// lpd_regs.svh: offsets, field positions, reset values and frame codes
// of the position command decoder. assumes 32-bit apb words, 12-bit offsets.
`ifndef LPD_REGS_SVH
`define LPD_REGS_SVH

`define LPD_DIAG_ID 8'h3C
`define LPD_APP_MARKER 8'h80
`define LPD_CMD_MOVE 7'h0B
`define LPD_LEN_DIAG 4'h8
`define LPD_LEN_SHORT1 4'h2
`define LPD_LEN_SHORT2 4'h4
`define LPD_LEN_SHORT4 4'h8
`define LPD_LEN_PROFILE 4'h4
`define LPD_GRP_SHORT2 2'h2
`define LPD_GRP_SHORT4 2'h3

`define LPD_OFS_CTRL 12'h000
`define LPD_OFS_ID_SHORT1 12'h004
`define LPD_OFS_ID_SHORT2 12'h008
`define LPD_OFS_ID_SHORT4 12'h00C
`define LPD_OFS_ID_PROFILE 12'h010
`define LPD_OFS_STATUS 12'h014
`define LPD_OFS_PROFILE 12'h018
`define LPD_OFS_COUNTS 12'h01C

`define LPD_STATUS_NODE_LSB 16
`define LPD_COUNTS_DISC_LSB 8

`define LPD_RST_MS 2'h0
`define LPD_RST_ID_SHORT1 6'h01
`define LPD_RST_ID_SHORT2 6'h21
`define LPD_RST_ID_SHORT4 6'h31
`define LPD_RST_ID_PROFILE 6'h22

`endif

// File: hw/lpd_pkg.sv
// lpd_pkg: types shared by the position command decoder files.
// assumes nothing of its surroundings.
package lpd_pkg;
  typedef enum {LPD_ST_IDLE, LPD_ST_CHECK} lpd_state_t;
endpackage : lpd_pkg

// File: hw/lpd_frame_check.sv
// lpd_frame_check: identifier parity and classic data checksum of a frame.
// assumes the frame words are held stable by the caller; purely combinational.
`timescale 1ns/1ps
module lpd_frame_check (
  input wire logic [7:0] frame_id,
  input wire logic [3:0] frame_len,
  input wire logic [63:0] frame_data,
  input wire logic [7:0] frame_chk,
  output logic parity_ok,
  output logic sum_ok
);
  // eight-bit add with end-around carry
  function automatic logic [7:0] lpd_add_carry(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : lpd_add_carry

  logic [7:0] acc;
  logic p0;
  logic p1;

  always_comb begin
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(frame_len)) begin
        acc = lpd_add_carry(acc, frame_data[8*i +: 8]);
      end
    end
    sum_ok = (~acc == frame_chk);
    p0 = frame_id[0] ^ frame_id[1] ^ frame_id[2] ^ frame_id[4];
    p1 = ~(frame_id[1] ^ frame_id[3] ^ frame_id[4] ^ frame_id[5]);
    parity_ok = (frame_id[6] == p0) && (frame_id[7] == p1);
  end
endmodule : lpd_frame_check

// File: hw/lpd_decoder.sv
// lpd_decoder: decodes received position write frames into a target and
// profile codes; apb slave for identifiers, resolution and status.
// assumes a frame receiver on pclk that presents whole frames, parity bits
// included, with a one-cycle frame_valid; straps come from pins.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "lpd_regs.svh"
module lpd_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid,
  input wire logic [7:0] frame_id,
  input wire logic [3:0] frame_len,
  input wire logic [63:0] frame_data,
  input wire logic [7:0] frame_chk,
  output logic frame_ready,
  input wire logic [3:0] otp_node_number,
  input wire logic strap_pin_zero,
  input wire logic strap_pin_one,
  input wire logic strap_pin_two,
  input wire logic ignore_short,
  output logic [15:0] target_pos,
  output logic target_load,
  output logic profile_load,
  output logic [3:0] vmax_code,
  output logic [3:0] vmin_code,
  output logic [3:0] stall_threshold_code,
  output logic [3:0] acc_code
);
  // internal scale: microsteps, a half step being 2**microstep_resolution of them
  function automatic logic [15:0] lpd_scale(input logic [10:0] raw, input logic [1:0] ms);
    logic signed [15:0] v;
    v = {{5{raw[10]}}, raw};
    return 16'(v <<< ms);
  endfunction : lpd_scale

  logic [2:0] strap_s1_ff;
  logic [2:0] strap_s2_ff;
  lpd_pkg::lpd_state_t state_ff, nxt_state;
  logic [7:0] id_ff, nxt_id;
  logic [3:0] len_ff, nxt_len;
  logic [63:0] data_ff, nxt_data;
  logic [7:0] chk_ff, nxt_chk;
  logic frame_ready_ff, nxt_frame_ready;
  logic [15:0] target_ff, nxt_target;
  logic target_load_ff, nxt_target_load;
  logic profile_load_ff, nxt_profile_load;
  logic [15:0] codes_ff, nxt_codes;
  logic [7:0] accept_cnt_ff, nxt_accept_cnt;
  logic [7:0] discard_cnt_ff, nxt_discard_cnt;
  logic [1:0] microstep_resolution_ff, nxt_microstep_resolution;
  logic [5:0] id_short1_ff, nxt_id_short1;
  logic [5:0] id_short2_ff, nxt_id_short2;
  logic [5:0] id_short4_ff, nxt_id_short4;
  logic [5:0] id_profile_ff, nxt_id_profile;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  logic parity_ok;
  logic sum_ok;
  logic [7:0] b [1:8];
  logic [6:0] phys;
  logic diag_frame, diag_m1, diag_m2, dyn_frame;
  logic short1_frame, short2_frame, short4_frame, short_frame, profile_frame;
  logic short_hit, decode_ok;
  logic [10:0] short_raw;
  logic [15:0] short_target;

  lpd_frame_check u_check (
    .frame_id(id_ff),
    .frame_len(len_ff),
    .frame_data(data_ff),
    .frame_chk(chk_ff),
    .parity_ok(parity_ok),
    .sum_ok(sum_ok)
  );

  // straps are pins: two flops before anything looks at them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_ff <= 3'h0;
      strap_s2_ff <= 3'h0;
    end else begin
      strap_s1_ff <= {strap_pin_two, strap_pin_one, strap_pin_zero};
      strap_s2_ff <= strap_s1_ff;
    end
  end

  always_comb begin
    for (int i = 1; i <= 8; i++) begin
      b[i] = data_ff[8*i-1 -: 8];
    end
    phys = {strap_s2_ff, otp_node_number};
    diag_frame = (id_ff == `LPD_DIAG_ID) && (len_ff == `LPD_LEN_DIAG)
      && (b[1] == `LPD_APP_MARKER) && (b[2] == {1'b1, `LPD_CMD_MOVE})
      && b[3][7] && b[6][7];
    diag_m1 = (b[3][6:0] == phys);
    diag_m2 = (b[6][6:0] == phys);
    dyn_frame = (id_ff != `LPD_DIAG_ID);
    // the profile identifier is matched as it sits on the wire
    profile_frame = dyn_frame && (id_ff[5:0] == id_profile_ff)
      && (id_ff[5:4] == `LPD_GRP_SHORT2) && (len_ff == `LPD_LEN_PROFILE);
    short1_frame = dyn_frame && !id_ff[5] && (id_ff[5:0] == id_short1_ff)
      && (len_ff == `LPD_LEN_SHORT1);
    short2_frame = dyn_frame && !profile_frame && (id_ff[5:0] == id_short2_ff)
      && (id_ff[5:4] == `LPD_GRP_SHORT2) && (len_ff == `LPD_LEN_SHORT2);
    short4_frame = dyn_frame && (id_ff[5:0] == id_short4_ff)
      && (id_ff[5:4] == `LPD_GRP_SHORT4) && (len_ff == `LPD_LEN_SHORT4);
    short_frame = short1_frame || short2_frame || short4_frame;
    short_hit = 1'b0;
    short_raw = 11'h000;
    if (short1_frame) begin
      short_hit = !b[1][4] || (b[1][3:0] == phys[3:0]);
      short_raw = {b[1][7:5], b[2]};
    end else if (short2_frame || short4_frame) begin
      // first pair carrying our node wins; pairs need the fixed one in bit 4
      for (int p = 0; p < 4; p++) begin
        if ((p < 2 || short4_frame) && !short_hit && b[2*p+1][4]
            && (b[2*p+1][3:0] == phys[3:0])) begin
          short_hit = 1'b1;
          short_raw = {b[2*p+1][7:5], b[2*p+2]};
        end
      end
    end
    short_target = lpd_scale(short_raw, microstep_resolution_ff);
    decode_ok = sum_ok && (!dyn_frame || parity_ok);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_id = id_ff;
    nxt_len = len_ff;
    nxt_data = data_ff;
    nxt_chk = chk_ff;
    nxt_target = target_ff;
    nxt_target_load = 1'b0;
    nxt_profile_load = 1'b0;
    nxt_codes = codes_ff;
    nxt_accept_cnt = accept_cnt_ff;
    nxt_discard_cnt = discard_cnt_ff;
    case (state_ff)
      lpd_pkg::LPD_ST_IDLE: begin
        if (frame_valid && frame_ready_ff) begin
          nxt_id = frame_id;
          nxt_len = frame_len;
          nxt_data = frame_data;
          nxt_chk = frame_chk;
          nxt_state = lpd_pkg::LPD_ST_CHECK;
        end
      end
      lpd_pkg::LPD_ST_CHECK: begin
        nxt_state = lpd_pkg::LPD_ST_IDLE;
        if (!decode_ok) begin
          nxt_discard_cnt = discard_cnt_ff + 8'h01;
        end else if (diag_frame && (diag_m1 || diag_m2)) begin
          nxt_target = diag_m1 ? {b[4], b[5]} : {b[7], b[8]};
          nxt_target_load = 1'b1;
          nxt_accept_cnt = accept_cnt_ff + 8'h01;
        end else if (profile_frame) begin
          nxt_target = {b[1], b[2]};
          nxt_codes = {b[3], b[4]};
          nxt_target_load = 1'b1;
          nxt_profile_load = 1'b1;
          nxt_accept_cnt = accept_cnt_ff + 8'h01;
        end else if (short_frame && short_hit && !ignore_short) begin
          nxt_target = short_target;
          nxt_target_load = 1'b1;
          nxt_accept_cnt = accept_cnt_ff + 8'h01;
        end else if (diag_frame || short_frame) begin
          nxt_discard_cnt = discard_cnt_ff + 8'h01;
        end
      end
      default: nxt_state = lpd_pkg::LPD_ST_IDLE;
    endcase
    nxt_frame_ready = (nxt_state == lpd_pkg::LPD_ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= lpd_pkg::LPD_ST_IDLE;
      id_ff <= 8'h00;
      len_ff <= 4'h0;
      data_ff <= 64'h0000000000000000;
      chk_ff <= 8'h00;
      frame_ready_ff <= 1'b0;
      target_ff <= 16'h0000;
      target_load_ff <= 1'b0;
      profile_load_ff <= 1'b0;
      codes_ff <= 16'h0000;
      accept_cnt_ff <= 8'h00;
      discard_cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      id_ff <= nxt_id;
      len_ff <= nxt_len;
      data_ff <= nxt_data;
      chk_ff <= nxt_chk;
      frame_ready_ff <= nxt_frame_ready;
      target_ff <= nxt_target;
      target_load_ff <= nxt_target_load;
      profile_load_ff <= nxt_profile_load;
      codes_ff <= nxt_codes;
      accept_cnt_ff <= nxt_accept_cnt;
      discard_cnt_ff <= nxt_discard_cnt;
    end
  end

  // apb: one wait state, answer registered; writes land on the pready edge
  always_comb begin
    nxt_microstep_resolution = microstep_resolution_ff;
    nxt_id_short1 = id_short1_ff;
    nxt_id_short2 = id_short2_ff;
    nxt_id_short4 = id_short4_ff;
    nxt_id_profile = id_profile_ff;
    nxt_pready = psel && penable && !pready_ff;
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (nxt_pready) begin
      case (paddr)
        `LPD_OFS_CTRL: nxt_prdata = {30'h00000000, microstep_resolution_ff};
        `LPD_OFS_ID_SHORT1: nxt_prdata = {26'h0000000, id_short1_ff};
        `LPD_OFS_ID_SHORT2: nxt_prdata = {26'h0000000, id_short2_ff};
        `LPD_OFS_ID_SHORT4: nxt_prdata = {26'h0000000, id_short4_ff};
        `LPD_OFS_ID_PROFILE: nxt_prdata = {26'h0000000, id_profile_ff};
        `LPD_OFS_STATUS: begin
          nxt_prdata = {16'h0000, target_ff};
          nxt_prdata[`LPD_STATUS_NODE_LSB +: 7] = phys;
        end
        `LPD_OFS_PROFILE: nxt_prdata = {16'h0000, codes_ff};
        `LPD_OFS_COUNTS: begin
          nxt_prdata = {24'h000000, accept_cnt_ff};
          nxt_prdata[`LPD_COUNTS_DISC_LSB +: 8] = discard_cnt_ff;
        end
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready_ff && pwrite) begin
      case (paddr)
        `LPD_OFS_CTRL: nxt_microstep_resolution = pwdata[1:0];
        `LPD_OFS_ID_SHORT1: nxt_id_short1 = pwdata[5:0];
        `LPD_OFS_ID_SHORT2: nxt_id_short2 = pwdata[5:0];
        `LPD_OFS_ID_SHORT4: nxt_id_short4 = pwdata[5:0];
        `LPD_OFS_ID_PROFILE: nxt_id_profile = pwdata[5:0];
        default: nxt_microstep_resolution = microstep_resolution_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      microstep_resolution_ff <= `LPD_RST_MS;
      id_short1_ff <= `LPD_RST_ID_SHORT1;
      id_short2_ff <= `LPD_RST_ID_SHORT2;
      id_short4_ff <= `LPD_RST_ID_SHORT4;
      id_profile_ff <= `LPD_RST_ID_PROFILE;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      microstep_resolution_ff <= nxt_microstep_resolution;
      id_short1_ff <= nxt_id_short1;
      id_short2_ff <= nxt_id_short2;
      id_short4_ff <= nxt_id_short4;
      id_profile_ff <= nxt_id_profile;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign frame_ready = frame_ready_ff;
  assign target_pos = target_ff;
  assign target_load = target_load_ff;
  assign profile_load = profile_load_ff;
  assign {vmax_code, vmin_code, stall_threshold_code, acc_code} = codes_ff;

  wire in_check = (state_ff == lpd_pkg::LPD_ST_CHECK);

  sequence s_take;
    frame_valid && frame_ready_ff;
  endsequence
  sequence s_decide;
    in_check ##1 (state_ff == lpd_pkg::LPD_ST_IDLE) && frame_ready_ff;
  endsequence

  property p_frame_flow;
    @(posedge pclk) disable iff (!presetn) s_take |=> s_decide;
  endproperty
  a_frame_flow: assert property (p_frame_flow) else $error("frame not decided in two cycles");

  property p_diag_first;
    @(posedge pclk) disable iff (!presetn)
      in_check && decode_ok && diag_frame && diag_m1 |=>
      target_load_ff && target_ff == {$past(b[4]), $past(b[5])};
  endproperty
  a_diag_first: assert property (p_diag_first) else $error("first setpoint not loaded");

  property p_diag_other;
    @(posedge pclk) disable iff (!presetn)
      in_check && diag_frame && !diag_m1 && !diag_m2 |=> !target_load_ff && $stable(target_ff);
  endproperty
  a_diag_other: assert property (p_diag_other) else $error("foreign diag frame used");

  property p_bad_sum;
    @(posedge pclk) disable iff (!presetn)
      in_check && !sum_ok |=> !target_load_ff && !profile_load_ff && $stable(codes_ff);
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum frame acted on");

  property p_ignored;
    @(posedge pclk) disable iff (!presetn)
      in_check && short_frame && !diag_frame && !profile_frame && ignore_short |=> !target_load_ff;
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored short move loaded");

  property p_broadcast;
    @(posedge pclk) disable iff (!presetn)
      in_check && decode_ok && short1_frame && !b[1][4] && !ignore_short |=> target_load_ff;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("all-nodes short move missed");

  property p_parity;
    @(posedge pclk) disable iff (!presetn)
      in_check && dyn_frame && !parity_ok |=> !target_load_ff ##1 !target_load_ff;
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity frame acted on");

  property p_profile;
    @(posedge pclk) disable iff (!presetn)
      in_check && decode_ok && profile_frame |=>
      profile_load_ff && target_load_ff && target_ff == {$past(b[1]), $past(b[2])} &&
      {vmax_code, vmin_code, stall_threshold_code, acc_code} == {$past(b[3]), $past(b[4])};
  endproperty
  a_profile: assert property (p_profile) else $error("profile codes not loaded");

  property p_half_step;
    @(posedge pclk) disable iff (!presetn)
      in_check && decode_ok && short_frame && short_hit && !ignore_short && !profile_frame |=>
      target_load_ff && ((target_ff & ~(16'hFFFF << microstep_resolution_ff)) == 16'h0000);
  endproperty
  a_half_step: assert property (p_half_step) else $error("short target off half step");

  property p_apb_pulse;
    @(posedge pclk) disable iff (!presetn) pready_ff |=> !pready_ff;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready held two cycles");
endmodule : lpd_decoder

// File: bench/lpd_lin_master_model.sv
// lpd_lin_master_model: bus master stand-in that hands whole frames to the decoder.
// assumes one clock shared with the decoder; the bench calls send for each frame.
`timescale 1ns/1ps
module lpd_lin_master_model (
  input wire logic pclk,
  input wire logic frame_ready,
  output logic frame_valid,
  output logic [7:0] frame_id,
  output logic [3:0] frame_len,
  output logic [63:0] frame_data,
  output logic [7:0] frame_chk
);
  initial begin
    frame_valid = 1'b0;
    frame_id = 8'h00;
    frame_len = 4'h0;
    frame_data = 64'h0;
    frame_chk = 8'h00;
  end

  // bad_par and bad_chk corrupt the frame on purpose; ok falls if the port never opens
  task automatic send(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d,
      input logic bad_par, input logic bad_chk, output logic ok);
    int s;
    int n;
    logic [7:0] pid;
    logic [7:0] c;
    s = 0;
    for (int i = 0; i < len; i++) begin
      s = s + d[8*i +: 8];
      if (s > 255) s = s - 255;
    end
    c = ~8'(s) ^ {7'h0, bad_chk};
    // the diagnostic id works out to parity 00 by itself
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    pid = pid ^ {1'b0, bad_par, 6'h00};
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (frame_ready !== 1'b1 && n < 50);
    ok = (n < 50);
    @(posedge pclk);
    frame_valid <= ok;
    frame_id <= pid;
    frame_len <= len;
    frame_data <= d;
    frame_chk <= c;
    @(posedge pclk);
    // released id, data and checksum lines show the inverse so a late sample cannot match by luck
    frame_valid <= 1'b0;
    frame_id <= ~pid;
    frame_data <= ~d;
    frame_chk <= ~c;
  endtask : send
endmodule : lpd_lin_master_model

// File: bench/tb_top.sv
// tb_top: self-checking bench for the position command decoder.
// assumes lpd_decoder and the master model on one 100 MHz clock.
`timescale 1ns/1ps
`include "lpd_regs.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, frame_valid, frame_ready, target_load, profile_load;
  logic [7:0] frame_id, frame_chk;
  logic [3:0] frame_len, vmax_code, vmin_code, stall_threshold_code, acc_code;
  logic [63:0] frame_data;
  logic [3:0] otp_node_number = 4'h0;
  logic ignore_short = 1'b0;
  logic [15:0] target_pos;
  int num_errors = 0;
  int tests_run = 0;
  int acc_n = 0;
  int disc_n = 0;
  logic [1:0] ms = 2'h0;
  logic [15:0] codes_m = 16'h0;
  logic [15:0] tgt_m = 16'h0;
  logic [32:0] exp_q[$];
  localparam logic [11:0] OFS [5] = '{`LPD_OFS_CTRL, `LPD_OFS_ID_SHORT1,
      `LPD_OFS_ID_SHORT2, `LPD_OFS_ID_SHORT4, `LPD_OFS_ID_PROFILE};
  localparam logic [31:0] RST [5] = '{32'h0, 32'h01, 32'h21, 32'h31, 32'h22};

  always #5 pclk = ~pclk;

  lpd_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_valid(frame_valid), .frame_id(frame_id),
    .frame_len(frame_len), .frame_data(frame_data), .frame_chk(frame_chk),
    .frame_ready(frame_ready), .otp_node_number(otp_node_number),
    .strap_pin_zero(1'b1), .strap_pin_one(1'b1), .strap_pin_two(1'b1),
    .ignore_short(ignore_short), .target_pos(target_pos), .target_load(target_load),
    .profile_load(profile_load), .vmax_code(vmax_code), .vmin_code(vmin_code),
    .stall_threshold_code(stall_threshold_code), .acc_code(acc_code));

  lpd_lin_master_model master (.pclk(pclk), .frame_ready(frame_ready),
    .frame_valid(frame_valid), .frame_id(frame_id), .frame_len(frame_len),
    .frame_data(frame_data), .frame_chk(frame_chk));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", w, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic stall(input string w);
    $display("ERROR %s expected answer seen none", w);
    num_errors++;
    wrap_up();
  endtask : stall

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // answer is read as sampled at the edge that ends the access, then released
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stall("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // kind 0: dropped and counted, 1: loads a target, 2: dropped uncounted
  task automatic frame(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d,
      input logic bp, input logic bc, input int kind, input logic prof,
      input logic [15:0] tgt);
    logic ok;
    if (kind == 1) begin
      if (prof) codes_m = {d[23:16], d[31:24]};
      exp_q.push_back({prof, codes_m, tgt});
      tgt_m = tgt;
      acc_n++;
    end
    if (kind == 0) disc_n++;
    master.send(id, len, d, bp, bc, ok);
    if (!ok) stall("frame_ready");
    repeat (2) @(posedge pclk);
  endtask : frame

  function automatic logic [15:0] sp(input logic [10:0] p, input logic f,
      input logic [3:0] a);
    return {p[7:0], p[10:8], f, a};
  endfunction : sp

  function automatic logic [15:0] sh(input logic [10:0] p);
    return {{5{p[10]}}, p} << ms;
  endfunction : sh

  function automatic logic [63:0] dg(input logic [6:0] a, input logic [15:0] s,
      input logic [6:0] b, input logic [15:0] t);
    return {t[7:0], t[15:8], 1'b1, b, s[7:0], s[15:8], 1'b1, a, 8'h8B, 8'h80};
  endfunction : dg

  always @(negedge pclk) begin : mon
    logic [32:0] e;
    if (target_load === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected target_load", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        chk("target_pos", {16'h0, e[15:0]}, {16'h0, target_pos});
        chk("profile_load", {31'h0, e[32]}, {31'h0, profile_load});
        chk("codes", {16'h0, e[31:16]},
            {16'h0, vmax_code, vmin_code, stall_threshold_code, acc_code});
      end
    end
  end

  initial begin
    logic [31:0] rd;
    logic er;
    logic [10:0] p, q;
    logic [15:0] s, t, c;
    logic [3:0] n, o;
    logic [6:0] me, ot;
    logic [63:0] d;
    void'($urandom(32'h6851A47D));
    otp_node_number = 4'($urandom);
    n = otp_node_number;
    o = n ^ 4'h5;
    me = {3'h7, n};
    ot = {3'h7, o};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, OFS[i], 32'h0, rd, er);
      chk("reset value", RST[i], rd);
    end
    apb(1'b0, `LPD_OFS_STATUS, 32'h0, rd, er);
    chk("status node", {25'h0, me}, {25'h0, rd[22:16]});
    apb(1'b1, 12'h020, 32'hFFFFFFFF, rd, er);
    apb(1'b0, 12'h020, 32'h0, rd, er);
    chk("unmapped pslverr", 32'h1, {31'h0, er});
    chk("unmapped prdata", 32'h0, rd);
    ms = 2'($urandom);
    apb(1'b1, `LPD_OFS_CTRL, {30'h0, ms}, rd, er);
    apb(1'b0, `LPD_OFS_CTRL, 32'h0, rd, er);
    chk("resolution", {30'h0, ms}, rd);
    $display("test registers done");
    s = 16'($urandom);
    c = 16'($urandom);
    d = {32'h0, c[7:0], c[15:8], s[7:0], s[15:8]};
    frame(6'h22, 4'h4, d, 1'b0, 1'b0, 1, 1'b1, s);
    d[23:16] = ~d[23:16];
    frame(6'h22, 4'h4, d, 1'b0, 1'b1, 0, 1'b1, s);
    $display("test profile done");
    for (int i = 0; i < 6; i++) begin
      p = (i == 0) ? 11'h400 : 11'($urandom);
      frame(6'h01, 4'h2, {48'h0, sp(p, i % 3 != 2, (i % 3 == 0) ? n : o)}, 1'b0, 1'b0,
          (i % 3 == 1) ? 0 : 1, 1'b0, sh(p));
    end
    ignore_short <= 1'b1;
    frame(6'h01, 4'h2, {48'h0, sp(p, 1'b1, n)}, 1'b0, 1'b0, 0, 1'b0, 16'h0);
    ignore_short <= 1'b0;
    frame(6'h01, 4'h2, {48'h0, sp(p, 1'b1, n)}, 1'b1, 1'b0, 0, 1'b0, 16'h0);
    $display("test one-motor short done");
    p = 11'($urandom);
    q = 11'($urandom);
    frame(6'h21, 4'h4, {32'h0, sp(q, 1'b1, n), sp(p, 1'b1, o)}, 1'b0, 1'b0, 1, 1'b0,
        sh(q));
    frame(6'h21, 4'h4, {32'h0, sp(q, 1'b1, o), sp(p, 1'b1, o)}, 1'b0, 1'b0, 0, 1'b0,
        16'h0);
    for (int k = 0; k < 4; k++) begin
      q = 11'($urandom);
      for (int j = 0; j < 4; j++) d[16*j +: 16] = sp((j == k) ? q : p, 1'b1, (j == k) ? n : o);
      frame(6'h31, 4'h8, d, 1'b0, 1'b0, 1, 1'b0, sh(q));
    end
    $display("test multi-motor short done");
    s = 16'h8000;
    t = 16'($urandom);
    frame(6'h3C, 4'h8, dg(ot, t, me, s), 1'b0, 1'b0, 1, 1'b0, s);
    frame(6'h3C, 4'h8, dg(me, t, me, s), 1'b0, 1'b0, 1, 1'b0, t);
    frame(6'h3C, 4'h8, dg(ot, t, ot, s), 1'b0, 1'b0, 0, 1'b0, 16'h0);
    // low four bits match, strap bits do not: the full seven bits must compare
    frame(6'h3C, 4'h8, dg({3'h3, n}, t, {3'h5, n}, s), 1'b0, 1'b0, 0, 1'b0, 16'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, `LPD_OFS_COUNTS, 32'h0, rd, er);
    chk("counts", {16'h0, disc_n[7:0], acc_n[7:0]}, {16'h0, rd[15:0]});
    apb(1'b0, `LPD_OFS_STATUS, 32'h0, rd, er);
    chk("status target", {16'h0, tgt_m}, {16'h0, rd[15:0]});
    d = dg(me, t, ot, s);
    d[7:0] = 8'h81;
    frame(6'h3C, 4'h8, d, 1'b0, 1'b0, 2, 1'b0, 16'h0);
    repeat (3) @(posedge pclk);
    chk("pending loads", 32'h0, exp_q.size());
    $display("test two-motor diagnostic done");
    wrap_up();
  end
endmodule : tb_top
